// >>> dv/apsq_axis_ctrl_bench.sv
// Self-checking bench for the axis sequencer through its register port
`timescale 1ns/10ps
module apsq_axis_ctrl_bench;
    import apsq_pkg::*;
    // ==========================================================
    // Signals
    logic               clk, rst, wr, rd, pin, serr;
    logic        [7:0]  addr;
    logic        [15:0] wdata, rdata, d;
    logic signed [15:0] valve, pos, pa, pb, la, lb;
    logic               ready, inpos;
    int                 error_cnt, compares, n;
    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    apsq_axis_ctrl #(.STEP_DIV(4)) i_dut (.i_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_enable_pin(pin),
        .i_sensor_err(serr), .i_pos(pos), .i_press_a(pa), .i_press_b(pb),
        .o_valve(valve), .o_ready(ready), .o_inpos(inpos));
    apsq_plant i_plant (.i_clk(clk), .i_rst(rst), .i_valve(valve), .i_load_a(la),
        .i_load_b(lb), .o_pos(pos), .o_press_a(pa), .o_press_b(pb));
    // ==========================================================
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // Taken at the closing edge, before the design moves on
        @(posedge clk);
        v = rdata;
    endtask
    task automatic give_verdict();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; pin = 1'b0; serr = 1'b0;
        addr = 8'h00; wdata = 16'h0000; error_cnt = 0; compares = 0;
        la = 16'sh0000; lb = 16'sh0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped read, idle output
        rd_reg(APSQ_CTRL_OFS, d); check(d, 16'h0040);
        rd_reg(APSQ_GAIN_OFS, d); check(d, 16'h0100);
        rd_reg(APSQ_LIMA_OFS, d); check(d, 16'h7FFF);
        rd_reg(8'h3C, d); check(d, 16'h0000);
        check(valve, 16'h0000);
        $display("reset test done");
        // Enable: ready, hold in closed loop at present position
        pin <= 1'b1;
        wr_reg(APSQ_CTRL_OFS, 16'h0001);
        repeat (6) @(posedge clk);
        check({15'h0000, ready}, 16'h0001);
        rd_reg(APSQ_STAT_OFS, d); check({8'h00, d[7:4], 3'h0, d[0]}, 16'h0041);
        serr <= 1'b1;
        repeat (3) @(posedge clk);
        check({15'h0000, ready}, 16'h0000);
        serr <= 1'b0;
        repeat (3) @(posedge clk);
        $display("ready test done");
        // Command position ignored without start, taken with it
        wr_reg(APSQ_CMDSPD_OFS, 16'h7FFF);
        wr_reg(APSQ_CMDPOS_OFS, 16'h0100);
        rd_reg(APSQ_TGT_OFS, d); check(d, 16'h0000);
        wr_reg(APSQ_CTRL_OFS, 16'h0043);
        rd_reg(APSQ_TGT_OFS, d); check(d, 16'h0100);
        check({15'h0000, inpos}, 16'h0000);
        n = 0;
        while (inpos !== 1'b1 && n < 3000) begin
            @(posedge clk); n++;
        end
        if (n == 3000) error_cnt++;
        #1 check({15'h0000, inpos}, 16'h0001);
        repeat (20) @(posedge clk);
        check({15'h0000, inpos}, 16'h0001);
        $display("move test done");
        // Manual open loop, then release back to hold
        wr_reg(APSQ_MANSPD_OFS, 16'h0100);
        wr_reg(APSQ_CTRL_OFS, 16'h0005);
        repeat (4) @(posedge clk);
        #1 check(valve, 16'h0100);
        wr_reg(APSQ_CTRL_OFS, 16'h0001);
        repeat (4) @(posedge clk);
        rd_reg(APSQ_STAT_OFS, d); check({12'h000, d[7:4]}, 16'h0004);
        rd_reg(APSQ_TGT_OFS, d); check({15'h0000, (pos - d) <= 16'sh0010}, 16'h0001);
        $display("manual test done");
        // Pressure limit: differential, then single chamber, then released onto pair B
        la <= 16'sh0300; lb <= 16'sh0100;
        wr_reg(APSQ_PSET_OFS, 16'h0100);
        wr_reg(APSQ_LIMB_OFS, 16'h0040);
        wr_reg(APSQ_CTRL_OFS, 16'h0301);
        repeat (3) @(posedge clk);
        check(valve, 16'hFF00);
        rd_reg(APSQ_STAT_OFS, d); check({15'h0000, d[3]}, 16'h0001);
        wr_reg(APSQ_CTRL_OFS, 16'h0101);
        repeat (3) @(posedge clk);
        check(valve, 16'hFE00);
        la <= 16'sh0000;
        wr_reg(APSQ_CTRL_OFS, 16'h0111);
        repeat (3) @(posedge clk);
        check(valve, 16'h0040);
        rd_reg(APSQ_STAT_OFS, d); check({15'h0000, d[3]}, 16'h0000);
        $display("pressure test done");
        // Fault: preset on the output, then preset disabled gives zero
        wr_reg(APSQ_PRESET_OFS, 16'h1234);
        pin <= 1'b0;
        repeat (8) @(posedge clk);
        #1 check(valve, 16'h1234);
        wr_reg(APSQ_CTRL_OFS, 16'h0401);
        repeat (3) @(posedge clk);
        #1 check(valve, 16'h0000);
        $display("fault test done");
        give_verdict();
    end
endmodule

// >>> dv/apsq_plant.sv
// Behavioural cylinder and sensor model on the far side of the valve output
`timescale 1ns/10ps
module apsq_plant (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    // Valve command and chamber loads
    input  wire logic signed [15:0] i_valve,
    input  wire logic signed [15:0] i_load_a,
    input  wire logic signed [15:0] i_load_b,
    // Sensor values
    output logic signed [15:0]      o_pos,
    output logic signed [15:0]      o_press_a,
    output logic signed [15:0]      o_press_b
);
    // ==========================================================
    // Cylinder integrates flow; scaled down so the loop settles slowly
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pos <= 16'sh0000;
        end else begin
            o_pos <= o_pos + (i_valve >>> 4);
        end
    end
    // Chamber pressures follow the load set by the bench
    assign o_press_a = i_load_a;
    assign o_press_b = i_load_b;
endmodule

// >>> rtl/apsq_axis_ctrl.sv
// Axis position sequencer with pressure limitation and fault output
// Contract
// - manual bits drive open loop at speed
// - manual release latches position as target
// - command position taken only with start
// - move at once, flag in-position on arrival
// - in-position holds in window or start
// - stroke-dependent mode adapts gain to stroke
// - following mode tracks generated profile error
// - compare measured position against supplied target
// - pressure feedback single or differential chamber
// - overpressure reduces output, negative side only
// - pressure limitation engages automatically
// - fault forces output to preset
// - preset drives to end, can disable
// - linear curve uses gain factor 1
// - first root curve factor 3, reset default
// - second root curve factor 5
// - two-slope gain around zero
// - deadband offset added to output
// - no pressure config means direct output
// - select bit picks deadband/limit pair
// - ready needs pin, bit, no sensor error
// - enable latches position, holds closed loop
`timescale 1ns/10ps
module apsq_axis_ctrl
    import apsq_pkg::*;
#(
    parameter int W        = APSQ_W,
    parameter int STEP_DIV = APSQ_STEP_DIV
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    // Register port
    input  wire logic [APSQ_AW-1:0]   i_addr,
    input  wire logic [W-1:0]         i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [W-1:0]         o_rdata,
    // Pins and sensor values
    input  wire logic                 i_enable_pin,
    input  wire logic                 i_sensor_err,
    input  wire logic signed [W-1:0]  i_pos,
    input  wire logic signed [W-1:0]  i_press_a,
    input  wire logic signed [W-1:0]  i_press_b,
    // Outputs
    output logic signed [W-1:0]       o_valve,
    output logic                      o_ready,
    output logic                      o_inpos
);
    // ==========================================================
    // State record
    typedef struct packed {
        apsq_mode_t         mode;     // Sequencer state
        logic               en_q1;    // Enable pin sync, first stage
        logic               en_q2;    // Enable pin sync, second stage
        logic [W-1:0]       ctrl;     // Control bits
        logic signed [W-1:0] cmd_pos; // Command position
        logic signed [W-1:0] cmd_spd; // Travel speed
        logic signed [W-1:0] man_spd; // Manual speed
        logic signed [W-1:0] p_set;   // Pressure setpoint
        logic signed [W-1:0] win;     // In-position window
        logic signed [W-1:0] preset;  // Fault output value
        logic signed [W-1:0] db_a;    // Deadband A
        logic signed [W-1:0] lim_a;   // Limit A
        logic signed [W-1:0] db_b;    // Deadband B
        logic signed [W-1:0] lim_b;   // Limit B
        logic signed [W-1:0] gain;    // Loop gain, 8.8
        logic signed [W-1:0] target;  // Active target
        logic signed [W-1:0] prof;    // Generated profile position
        logic signed [W-1:0] valve;   // Valve output
        logic               inpos;    // In-position flag
        logic               ready;    // Ready flag
        logic               p_act;    // Pressure limitation active
        logic [W-1:0]       div;      // Profile step divider
        logic [W-1:0]       rdata;    // Read data
    } apsq_state_t;

    apsq_state_t s_r;                  // Registered state
    apsq_state_t s_nxt;                // Next state

    // ==========================================================
    // Combinational helpers
    logic               ready_c;       // Ready condition this cycle
    logic               manual_c;      // Any manual bit set
    logic               closed_c;      // Closed loop states
    logic               near_c;        // Inside in-position window
    logic               over_c;        // Pressure above setpoint
    logic               accept_c;      // New command accepted
    logic               tick_c;        // Profile step enable
    logic signed [31:0] err_c;         // Control error
    logic signed [31:0] terr_c;        // Target minus position
    logic        [31:0] mag_c;         // Saturated error magnitude
    logic        [31:0] curve_c;       // Braking curve value
    logic        [31:0] raw_c;         // Gain-scaled magnitude
    logic        [31:0] shp_c;         // Shaped magnitude
    logic signed [31:0] ctrl_c;        // Position controller result
    logic signed [31:0] out_c;         // Output before fault handling
    logic signed [31:0] fb_c;          // Pressure feedback
    logic signed [31:0] pcmd_c;        // Pressure controller result
    logic signed [31:0] db_c;          // Selected deadband
    logic signed [31:0] lim_c;         // Selected limit
    logic        [W-1:0] sq_c;         // Root of scaled magnitude
    logic [1:0]         curve_sel;     // Braking curve code

    assign curve_sel = s_r.ctrl[APSQ_C_CURVE +: 2];

    // Square root stage feeding both root curves
    apsq_isqrt #(
        .W      (W)
    ) u_isqrt (
        .i_val  ((mag_c << APSQ_SQ_SH)),
        .o_root (sq_c)
    );

    // ==========================================================
    // Next-state logic
    always_comb begin
        s_nxt       = s_r;
        // Only the second stage is read by logic
        s_nxt.en_q1 = i_enable_pin;
        s_nxt.en_q2 = s_r.en_q1;
        ready_c  = s_r.en_q2 && s_r.ctrl[APSQ_C_EN] && !i_sensor_err;
        manual_c = s_r.ctrl[APSQ_C_FWD] || s_r.ctrl[APSQ_C_REV];
        closed_c = (s_r.mode == APSQ_HOLD) || (s_r.mode == APSQ_MOVE);
        tick_c   = (s_r.div == W'(STEP_DIV - 1));
        s_nxt.div = tick_c ? '0 : s_r.div + W'(1);

        // Register writes; read-only and unmapped writes are dropped
        if (i_wr) begin
            case (i_addr)
                APSQ_CTRL_OFS:   s_nxt.ctrl    = i_wdata;
                APSQ_CMDPOS_OFS: s_nxt.cmd_pos = i_wdata;
                APSQ_CMDSPD_OFS: s_nxt.cmd_spd = i_wdata;
                APSQ_MANSPD_OFS: s_nxt.man_spd = i_wdata;
                APSQ_PSET_OFS:   s_nxt.p_set   = i_wdata;
                APSQ_WIN_OFS:    s_nxt.win     = i_wdata;
                APSQ_PRESET_OFS: s_nxt.preset  = i_wdata;
                APSQ_DBA_OFS:    s_nxt.db_a    = i_wdata;
                APSQ_LIMA_OFS:   s_nxt.lim_a   = i_wdata;
                APSQ_DBB_OFS:    s_nxt.db_b    = i_wdata;
                APSQ_LIMB_OFS:   s_nxt.lim_b   = i_wdata;
                APSQ_GAIN_OFS:   s_nxt.gain    = i_wdata;
                default: ;
            endcase
        end

        // Register reads; data stand only in the following cycle
        s_nxt.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                APSQ_CTRL_OFS:   s_nxt.rdata = s_r.ctrl;
                APSQ_CMDPOS_OFS: s_nxt.rdata = s_r.cmd_pos;
                APSQ_CMDSPD_OFS: s_nxt.rdata = s_r.cmd_spd;
                APSQ_MANSPD_OFS: s_nxt.rdata = s_r.man_spd;
                APSQ_PSET_OFS:   s_nxt.rdata = s_r.p_set;
                APSQ_WIN_OFS:    s_nxt.rdata = s_r.win;
                APSQ_PRESET_OFS: s_nxt.rdata = s_r.preset;
                APSQ_DBA_OFS:    s_nxt.rdata = s_r.db_a;
                APSQ_LIMA_OFS:   s_nxt.rdata = s_r.lim_a;
                APSQ_DBB_OFS:    s_nxt.rdata = s_r.db_b;
                APSQ_LIMB_OFS:   s_nxt.rdata = s_r.lim_b;
                APSQ_GAIN_OFS:   s_nxt.rdata = s_r.gain;
                APSQ_STAT_OFS:   s_nxt.rdata = {{(W-8){1'b0}}, s_r.mode, s_r.p_act,
                                                s_r.valve != s_r.preset, s_r.inpos, s_r.ready};
                APSQ_TGT_OFS:    s_nxt.rdata = s_r.target;
                APSQ_VALVE_OFS:  s_nxt.rdata = s_r.valve;
                default:         s_nxt.rdata = '0;
            endcase
        end

        // Error against target, or against the generated profile
        terr_c = 32'(s_r.target) - 32'(i_pos);
        err_c  = s_r.ctrl[APSQ_C_FOLLOW] ? 32'(s_r.prof) - 32'(i_pos) : terr_c;
        mag_c  = (err_c < 0) ? 32'(-err_c) : 32'(err_c);
        if (mag_c > 32'(APSQ_SAT)) mag_c = 32'(APSQ_SAT);
        near_c = ((terr_c < 0) ? -terr_c : terr_c) <= 32'(s_r.win);

        // Braking curve: root curves are steep near target, root-shaped far off
        case (curve_sel)
            APSQ_CURVE_RT3: curve_c = (32'(APSQ_FAC_RT3) * mag_c < 32'(sq_c)) ?
                                      32'(APSQ_FAC_RT3) * mag_c : 32'(sq_c);
            APSQ_CURVE_RT5: curve_c = (32'(APSQ_FAC_RT5) * mag_c < 32'(sq_c)) ?
                                      32'(APSQ_FAC_RT5) * mag_c : 32'(sq_c);
            default:        curve_c = 32'(APSQ_FAC_LIN) * mag_c;
        endcase
        // Gain scaled by remaining stroke through the curve
        raw_c = (32'(unsigned'(s_r.gain)) * curve_c) >> APSQ_GAIN_SH;
        if (!s_r.ctrl[APSQ_C_FOLLOW] && raw_c > 32'(s_r.cmd_spd))
            raw_c = 32'(s_r.cmd_spd);
        if (raw_c > 32'(APSQ_SAT)) raw_c = 32'(APSQ_SAT);

        // Deadband and limit pair chosen by the fieldbus select bit
        db_c  = s_r.ctrl[APSQ_C_PAIR] ? 32'(s_r.db_b)  : 32'(s_r.db_a);
        lim_c = s_r.ctrl[APSQ_C_PAIR] ? 32'(s_r.lim_b) : 32'(s_r.lim_a);
        // Two slopes meeting at the knee instead of an overlap jump
        shp_c = (raw_c < 32'(APSQ_KNEE)) ? raw_c << 1 : raw_c + 32'(APSQ_KNEE);
        // A large deadband loses fine low-speed control; keep it small
        if (raw_c != 0) shp_c = shp_c + 32'(db_c);
        if (32'(shp_c) > lim_c) shp_c = 32'(lim_c);

        if (s_r.ctrl[APSQ_C_PCFG])
            ctrl_c = (err_c < 0) ? -32'(shp_c) : 32'(shp_c);
        else
            ctrl_c = (err_c < 0) ? -32'(raw_c) : 32'(raw_c);

        // Open loop manual drive uses the manual speed only
        if (s_r.mode == APSQ_MANUAL)
            out_c = s_r.ctrl[APSQ_C_FWD] ? 32'(s_r.man_spd) :
                    (s_r.ctrl[APSQ_C_REV] ? -32'(s_r.man_spd) : 32'sd0);
        else
            out_c = ctrl_c;

        // Pressure limitation, pulling the output down only
        fb_c   = s_r.ctrl[APSQ_C_PDIFF] ? 32'(i_press_a) - 32'(i_press_b)
                                        : 32'(i_press_a);
        over_c = s_r.ctrl[APSQ_C_PCFG] && (fb_c > 32'(s_r.p_set));
        pcmd_c = 32'(s_r.p_set) - fb_c;
        s_nxt.p_act = over_c && (pcmd_c < out_c);
        if (s_nxt.p_act) out_c = pcmd_c;
        if (out_c < -32'(APSQ_SAT)) out_c = -32'(APSQ_SAT);

        // Sequencer
        accept_c = 1'b0;
        case (s_r.mode)
            APSQ_OFF: begin
                if (ready_c) begin
                    s_nxt.target = i_pos;
                    s_nxt.prof   = i_pos;
                    s_nxt.mode   = APSQ_HOLD;
                end
            end
            APSQ_MANUAL: begin
                if (!manual_c) begin
                    s_nxt.target = i_pos;
                    s_nxt.prof   = i_pos;
                    s_nxt.mode   = APSQ_HOLD;
                end
            end
            APSQ_HOLD, APSQ_MOVE: begin
                if (manual_c) begin
                    s_nxt.mode = APSQ_MANUAL;
                end else if (s_r.ctrl[APSQ_C_START] && s_r.cmd_pos != s_r.target) begin
                    accept_c     = 1'b1;
                    s_nxt.target = s_r.cmd_pos;
                    s_nxt.mode   = APSQ_MOVE;
                end else if (s_r.mode == APSQ_MOVE && near_c) begin
                    s_nxt.mode = APSQ_HOLD;
                end
                // Profile walks toward the target at the travel speed
                if (tick_c) begin
                    if (32'(s_r.target) - 32'(s_r.prof) > 32'(s_r.cmd_spd))
                        s_nxt.prof = s_r.prof + s_r.cmd_spd;
                    else if (32'(s_r.prof) - 32'(s_r.target) > 32'(s_r.cmd_spd))
                        s_nxt.prof = s_r.prof - s_r.cmd_spd;
                    else
                        s_nxt.prof = s_r.target;
                end
            end
            default: s_nxt.mode = APSQ_OFF;
        endcase
        if (!ready_c) s_nxt.mode = APSQ_OFF;

        // In-position: set on arrival, kept in window or while start holds
        s_nxt.inpos = ready_c && closed_c && !accept_c && !manual_c &&
                      (near_c || (s_r.inpos && s_r.ctrl[APSQ_C_START]));

        // Fault preset, or zero if it is switched off
        if (!ready_c)
            s_nxt.valve = s_r.ctrl[APSQ_C_FDIS] ? '0 : s_r.preset;
        else
            s_nxt.valve = W'(out_c);
        s_nxt.ready = ready_c;
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_r         <= '0;
            s_r.mode    <= APSQ_OFF;
            s_r.ctrl    <= APSQ_CTRL_RST;
            s_r.gain    <= APSQ_GAIN_RST;
            s_r.win     <= APSQ_WIN_RST;
            s_r.lim_a   <= APSQ_LIM_RST;
            s_r.lim_b   <= APSQ_LIM_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata = s_r.rdata;
    assign o_valve = s_r.valve;
    assign o_ready = s_r.ready;
    assign o_inpos = s_r.inpos;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    manual_drive_a: assert property ((s_r.mode == APSQ_MANUAL) && s_r.ctrl[APSQ_C_FWD] && ready_c
        && !s_r.ctrl[APSQ_C_PCFG] |=> o_valve == $past(s_r.man_spd))
        else $error("manual drive not at manual speed");
    release_latch_a: assert property ((s_r.mode == APSQ_MANUAL) && !manual_c && ready_c
        |=> (s_r.target == $past(i_pos)) && (s_r.mode == APSQ_HOLD))
        else $error("manual release did not latch position");
    no_start_a: assert property (closed_c && !s_r.ctrl[APSQ_C_START] && ready_c
        |=> $stable(s_r.target))
        else $error("target moved without start");
    inpos_set_a: assert property (closed_c && ready_c && near_c && !manual_c && !accept_c
        |=> o_inpos)
        else $error("in-position not flagged on arrival");
    inpos_drop_a: assert property (o_inpos && !s_r.ctrl[APSQ_C_START] && !near_c
        |=> !o_inpos)
        else $error("in-position kept outside window");
    ready_pin_a: assert property (!s_r.en_q2 |=> !o_ready)
        else $error("ready without enable pin");
    enable_hold_a: assert property ((s_r.mode == APSQ_OFF) && ready_c
        |=> (s_r.mode == APSQ_HOLD) && (s_r.target == $past(i_pos)) && o_ready)
        else $error("enable did not latch position");
    fault_out_a: assert property (!ready_c && !s_r.ctrl[APSQ_C_FDIS]
        |=> (o_valve == $past(s_r.preset)) && !o_ready)
        else $error("fault preset not applied");
    zero_out_a: assert property (!ready_c && s_r.ctrl[APSQ_C_FDIS] |=> o_valve == '0)
        else $error("output not zero while not ready");
    press_lim_a: assert property (ready_c && closed_c && over_c
        |=> $signed(o_valve) <= $signed(W'($past(ctrl_c))))
        else $error("pressure limit raised the output");
    // Without pressure configuration the valve word is the position result itself
    direct_out_a: assert property (ready_c && closed_c && !s_r.ctrl[APSQ_C_PCFG]
        |=> $signed(o_valve) == $signed(W'($past(ctrl_c))))
        else $error("unshaped output not taken directly");

    manual_c_c: cover property ((s_r.mode == APSQ_MANUAL) ##1 (s_r.mode == APSQ_HOLD));
    move_c:     cover property ((s_r.mode == APSQ_MOVE) ##[1:50] o_inpos);
    press_c:    cover property (s_r.p_act);
    fault_c:    cover property (o_ready ##1 !o_ready);
    diff_press_c: cover property (s_r.p_act && s_r.ctrl[APSQ_C_PDIFF]);
endmodule

// >>> rtl/apsq_isqrt.sv
// Combinational integer square root used by the root braking curves
`timescale 1ns/10ps
module apsq_isqrt #(
    parameter int W = 16
) (
    // Operand
    input  wire logic [2*W-1:0] i_val,
    // Result
    output logic      [W-1:0]   o_root
);
    // ==========================================================
    // Partial roots, one stage per result bit
    logic [W-1:0] root [0:W];

    assign root[0] = '0;

    // Each stage tries one more bit, keeping it if the square still fits
    for (genvar k = 0; k < W; k++) begin : g_bit
        logic [W-1:0]   trial;
        logic [2*W-1:0] sq;
        assign trial       = root[k] | (W'(1) << (W - 1 - k));
        assign sq          = {{W{1'b0}}, trial} * {{W{1'b0}}, trial};
        assign root[k + 1] = (sq <= i_val) ? trial : root[k];
    end

    assign o_root = root[W];
endmodule

// >>> rtl/apsq_pkg.sv
// Shared constants for the axis position and pressure sequencer
package apsq_pkg;
    // ==========================================================
    // Data widths
    localparam int APSQ_W        = 16;          // Position, speed and valve word width
    localparam int APSQ_AW       = 8;           // Register address width
    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] APSQ_CTRL_OFS   = 8'h00;  // Control bits
    localparam logic [7:0] APSQ_CMDPOS_OFS = 8'h04;  // Command position
    localparam logic [7:0] APSQ_CMDSPD_OFS = 8'h08;  // Travel speed
    localparam logic [7:0] APSQ_MANSPD_OFS = 8'h0C;  // Manual move speed
    localparam logic [7:0] APSQ_PSET_OFS   = 8'h10;  // Pressure setpoint
    localparam logic [7:0] APSQ_WIN_OFS    = 8'h14;  // In-position window
    localparam logic [7:0] APSQ_PRESET_OFS = 8'h18;  // Fault output preset
    localparam logic [7:0] APSQ_DBA_OFS    = 8'h1C;  // Deadband, pair A
    localparam logic [7:0] APSQ_LIMA_OFS   = 8'h20;  // Upper limit, pair A
    localparam logic [7:0] APSQ_DBB_OFS    = 8'h24;  // Deadband, pair B
    localparam logic [7:0] APSQ_LIMB_OFS   = 8'h28;  // Upper limit, pair B
    localparam logic [7:0] APSQ_GAIN_OFS   = 8'h2C;  // Position loop gain
    localparam logic [7:0] APSQ_STAT_OFS   = 8'h30;  // Status, read only
    localparam logic [7:0] APSQ_TGT_OFS    = 8'h34;  // Target, read only
    localparam logic [7:0] APSQ_VALVE_OFS  = 8'h38;  // Valve output, read only
    // ==========================================================
    // Control register fields
    localparam int APSQ_C_EN     = 0;   // Fieldbus enable
    localparam int APSQ_C_START  = 1;   // Start bit
    localparam int APSQ_C_FWD    = 2;   // Manual move, positive
    localparam int APSQ_C_REV    = 3;   // Manual move, negative
    localparam int APSQ_C_PAIR   = 4;   // Limit pair select
    localparam int APSQ_C_FOLLOW = 5;   // Following-error mode
    localparam int APSQ_C_CURVE  = 6;   // Braking curve, two bits
    localparam int APSQ_C_PCFG   = 8;   // Pressure limitation configured
    localparam int APSQ_C_PDIFF  = 9;   // Differential pressure feedback
    localparam int APSQ_C_FDIS   = 10;  // Fault preset disabled
    // ==========================================================
    // Braking curve codes
    localparam logic [1:0] APSQ_CURVE_LIN  = 2'h0;  // Linear, factor 1
    localparam logic [1:0] APSQ_CURVE_RT3  = 2'h1;  // Root curve, factor 3
    localparam logic [1:0] APSQ_CURVE_RT5  = 2'h2;  // Root curve, factor 5
    localparam int         APSQ_FAC_LIN    = 1;
    localparam int         APSQ_FAC_RT3    = 3;
    localparam int         APSQ_FAC_RT5    = 5;
    // ==========================================================
    // Reset values and loop constants
    localparam logic [15:0] APSQ_CTRL_RST  = 16'h0040;  // Root curve three selected
    localparam logic [15:0] APSQ_GAIN_RST  = 16'h0100;  // Unity gain
    localparam logic [15:0] APSQ_WIN_RST   = 16'h0010;
    localparam logic [15:0] APSQ_LIM_RST   = 16'h7FFF;
    localparam int          APSQ_GAIN_SH   = 8;         // Gain is 8.8 fixed point
    localparam int          APSQ_SQ_SH     = 8;         // Root curve scale
    localparam int          APSQ_KNEE      = 256;       // Two-slope knee
    localparam int          APSQ_STEP_DIV  = 200;       // Profile step every 1 us
    localparam int          APSQ_SAT       = 32767;
    // ==========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        APSQ_OFF    = 4'b0001,
        APSQ_MANUAL = 4'b0010,
        APSQ_HOLD   = 4'b0100,
        APSQ_MOVE   = 4'b1000
    } apsq_mode_t;
endpackage
